// file: rtl/exec_subset_pkg.sv
package exec_subset_pkg;

   localparam int WORD_W      = 8;
   localparam int INSTR_W     = 12;
   localparam int PC_W        = 11;
   localparam int FILE_AW     = 5;
   localparam int FILE_DEPTH  = 32;
   localparam int PAGE_W      = 2;

   // Instruction field positions
   localparam int FLD_ADDR_LO = 0;
   localparam int FLD_ADDR_HI = 4;
   localparam int FLD_DEST    = 5;
   localparam int FLD_BIT_LO  = 5;
   localparam int FLD_BIT_HI  = 7;
   localparam int FLD_LIT_LO  = 0;
   localparam int FLD_LIT_HI  = 7;

   // Opcode patterns and masks
   localparam logic [11:0] OP_AND_WORK_WITH_FILE      = 12'h140;
   localparam logic [11:0] MSK_AND_WORK_WITH_FILE     = 12'hfc0;
   localparam logic [11:0] OP_CLEAR_FILE_REGISTER     = 12'h060;
   localparam logic [11:0] MSK_CLEAR_FILE_REGISTER    = 12'hfe0;
   localparam logic [11:0] OP_CLEAR_WORKING_REGISTER  = 12'h040;
   localparam logic [11:0] OP_CLEAR_WATCHDOG_COUNTER  = 12'h004;
   localparam logic [11:0] OP_BIT_TEST_SKIP_WHEN_ZERO = 12'h600;
   localparam logic [11:0] OP_BIT_TEST_SKIP_WHEN_ONE  = 12'h700;
   localparam logic [11:0] OP_CALL                    = 12'h900;
   localparam logic [11:0] MSK_NIBBLE_OP              = 12'hf00;
   localparam logic [11:0] MSK_FULL                   = 12'hfff;
   localparam logic [11:0] OP_NOP                     = 12'h000;

   // Reset values
   localparam logic [10:0] RST_PC      = 11'h000;
   localparam logic [7:0]  RST_WORK    = 8'h00;
   localparam logic        RST_ZERO    = 1'b0;
   localparam logic        RST_FLAG_N  = 1'b1;
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;

   // Watchdog base tick: one enable pulse per this many clocks
   localparam logic [7:0]  WDT_TICK_DIV = 8'h10;

endpackage

// file: rtl/file_register_bank.sv
`timescale 1ns/1ps
module file_register_bank (
   input  wire logic       mclk_in,
   input  wire logic [4:0] rd_addr_in,
   output logic      [7:0] rd_data_out,
   input  wire logic       wr_en_in,
   input  wire logic [4:0] wr_addr_in,
   input  wire logic [7:0] wr_data_in
);
   import exec_subset_pkg::*;

   logic [7:0] mem [FILE_DEPTH];

   // Asynchronous read so a single-cycle op sees the operand in its own cycle
   assign rd_data_out = mem[rd_addr_in];

   always_ff @(posedge mclk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

endmodule

// file: rtl/watchdog_counter.sv
`timescale 1ns/1ps
module watchdog_counter (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic       clear_in,
   input  wire logic       prescaler_to_watchdog_in,
   output logic      [7:0] watchdog_count_out,
   output logic      [7:0] prescaler_count_out
);
   import exec_subset_pkg::*;

   logic [7:0] div;
   logic [7:0] next_div;
   logic [7:0] next_wdt;
   logic [7:0] next_pre;
   logic       tick;

   always_comb begin
      tick     = (div == WDT_TICK_DIV - 8'h01);
      next_div = tick ? ZERO_BYTE : div + 8'h01;
      next_wdt = watchdog_count_out;
      next_pre = prescaler_count_out;
      if (tick) begin
         if (prescaler_to_watchdog_in) begin
            next_pre = prescaler_count_out + 8'h01;
            if (prescaler_count_out == 8'hff) begin
               next_wdt = watchdog_count_out + 8'h01;
            end
         end else begin
            next_wdt = watchdog_count_out + 8'h01;
         end
      end
      // Clear beats a coincident tick
      if (clear_in) begin
         next_wdt = ZERO_BYTE;
         if (prescaler_to_watchdog_in) begin
            next_pre = ZERO_BYTE;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         div                 <= ZERO_BYTE;
         watchdog_count_out  <= ZERO_BYTE;
         prescaler_count_out <= ZERO_BYTE;
      end else begin
         div                 <= next_div;
         watchdog_count_out  <= next_wdt;
         prescaler_count_out <= next_pre;
      end
   end

endmodule

// file: rtl/exec_subset_core.sv
`timescale 1ns/1ps
// Function
// - AND work with file, update zero
// - Destination bit picks working or file
// - Skip when tested bit zero, flags untouched
// - Taken skip flushes prefetch, runs no-op
// - Skip when tested bit one, flags untouched
// - Clear working register, set zero flag
// - Call pushes program counter plus one
// - Call loads literal, page bits, bit8 zero
// - Call takes two cycles, no flags
// - Watchdog clear zeroes counter, assigned prescaler
// - Watchdog clear sets both status flags
// - Clear file register, set zero flag
module exec_subset_core (
   input  wire logic                                mclk_in,
   input  wire logic                                reset_in,
   input  wire logic [exec_subset_pkg::INSTR_W-1:0] instr_in,
   input  wire logic [exec_subset_pkg::PAGE_W-1:0]  page_select_in,
   input  wire logic                                prescaler_to_watchdog_in,
   output logic      [exec_subset_pkg::PC_W-1:0]    pc_out,
   output logic                                     stack_push_out,
   output logic      [exec_subset_pkg::PC_W-1:0]    stack_data_out,
   output logic      [exec_subset_pkg::WORD_W-1:0]  work_out,
   output logic                                     zero_flag_out,
   output logic                                     timeout_flag_n_out,
   output logic                                     powerdown_flag_n_out,
   output logic                                     flushing_out,
   output logic      [exec_subset_pkg::WORD_W-1:0]  watchdog_count_out,
   output logic      [exec_subset_pkg::WORD_W-1:0]  prescaler_count_out
);
   import exec_subset_pkg::*;

   typedef enum logic [1:0] {
      st_run   = 2'b01,
      st_flush = 2'b10
   } state_e;

   function automatic logic op_match(input logic [11:0] instr,
                                     input logic [11:0] pattern,
                                     input logic [11:0] mask);
      op_match = ((instr & mask) == pattern);
   endfunction

   state_e       state;
   state_e       next_state;
   logic [11:0]  ir;
   logic [11:0]  next_ir;
   logic [10:0]  next_pc;
   logic [7:0]   next_work;
   logic         next_zero;
   logic         next_timeout_n;
   logic         next_powerdown_n;
   logic         next_push;
   logic [10:0]  next_push_data;

   logic         exec;
   logic         is_and;
   logic         is_clear_file_register;
   logic         is_clear_working_register;
   logic         is_clear_watchdog_counter;
   logic         is_btz;
   logic         is_bto;
   logic         is_call;
   logic [4:0]   f_addr;
   logic [2:0]   bit_sel;
   logic         dest_file;
   logic [7:0]   file_rd;
   logic [7:0]   and_res;
   logic         tested_bit;
   logic         wr_en;
   logic [7:0]   wr_data;
   logic         wdt_clear;

   // No reset on the bank: a word reads undefined until first written
   file_register_bank u_files (
      .mclk_in     (mclk_in),
      .rd_addr_in  (f_addr),
      .rd_data_out (file_rd),
      .wr_en_in    (wr_en),
      .wr_addr_in  (f_addr),
      .wr_data_in  (wr_data)
   );

   watchdog_counter u_wdt (
      .mclk_in                  (mclk_in),
      .reset_in                 (reset_in),
      .clear_in                 (wdt_clear),
      .prescaler_to_watchdog_in (prescaler_to_watchdog_in),
      .watchdog_count_out       (watchdog_count_out),
      .prescaler_count_out      (prescaler_count_out)
   );

   // Decode of the held instruction; a flush cycle decodes nothing
   always_comb begin
      exec       = (state == st_run);
      is_and     = exec && op_match(ir, OP_AND_WORK_WITH_FILE, MSK_AND_WORK_WITH_FILE);
      is_clear_file_register    = exec && op_match(ir, OP_CLEAR_FILE_REGISTER, MSK_CLEAR_FILE_REGISTER);
      is_clear_working_register    = exec && op_match(ir, OP_CLEAR_WORKING_REGISTER, MSK_FULL);
      is_clear_watchdog_counter  = exec && op_match(ir, OP_CLEAR_WATCHDOG_COUNTER, MSK_FULL);
      is_btz     = exec && op_match(ir, OP_BIT_TEST_SKIP_WHEN_ZERO, MSK_NIBBLE_OP);
      is_bto     = exec && op_match(ir, OP_BIT_TEST_SKIP_WHEN_ONE, MSK_NIBBLE_OP);
      is_call    = exec && op_match(ir, OP_CALL, MSK_NIBBLE_OP);
      f_addr     = ir[FLD_ADDR_HI:FLD_ADDR_LO];
      bit_sel    = ir[FLD_BIT_HI:FLD_BIT_LO];
      dest_file  = ir[FLD_DEST];
      and_res    = work_out & file_rd;
      tested_bit = file_rd[bit_sel];
   end

   always_comb begin
      // Fetch always runs one word ahead of execution
      next_ir          = instr_in;
      next_pc          = pc_out + 11'h001;
      next_state       = st_run;
      next_work        = work_out;
      next_zero        = zero_flag_out;
      next_timeout_n   = timeout_flag_n_out;
      next_powerdown_n = powerdown_flag_n_out;
      next_push        = 1'b0;
      next_push_data   = stack_data_out;
      wr_en            = 1'b0;
      wr_data          = ZERO_BYTE;
      wdt_clear        = 1'b0;
      if (is_and) begin
         next_zero = (and_res == ZERO_BYTE);
         if (dest_file) begin
            wr_en   = 1'b1;
            wr_data = and_res;
         end else begin
            next_work = and_res;
         end
      end
      if (is_clear_file_register) begin
         wr_en     = 1'b1;
         wr_data   = ZERO_BYTE;
         next_zero = 1'b1;
      end
      if (is_clear_working_register) begin
         next_work = ZERO_BYTE;
         next_zero = 1'b1;
      end
      if (is_btz && !tested_bit) begin
         next_state = st_flush;
      end
      if (is_bto && tested_bit) begin
         next_state = st_flush;
      end
      if (is_call) begin
         // pc already points one past the call
         next_push      = 1'b1;
         next_push_data = pc_out;
         next_pc        = {page_select_in, 1'b0, ir[FLD_LIT_HI:FLD_LIT_LO]};
         next_state     = st_flush;
      end
      if (is_clear_watchdog_counter) begin
         wdt_clear        = 1'b1;
         next_timeout_n   = 1'b1;
         next_powerdown_n = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state                <= st_run;
         ir                   <= OP_NOP;
         pc_out               <= RST_PC;
         work_out             <= RST_WORK;
         zero_flag_out        <= RST_ZERO;
         timeout_flag_n_out   <= RST_FLAG_N;
         powerdown_flag_n_out <= RST_FLAG_N;
         stack_push_out       <= 1'b0;
         stack_data_out       <= RST_PC;
         flushing_out         <= 1'b0;
      end else begin
         state                <= next_state;
         ir                   <= next_ir;
         pc_out               <= next_pc;
         work_out             <= next_work;
         zero_flag_out        <= next_zero;
         timeout_flag_n_out   <= next_timeout_n;
         powerdown_flag_n_out <= next_powerdown_n;
         stack_push_out       <= next_push;
         stack_data_out       <= next_push_data;
         flushing_out         <= (next_state == st_flush);
      end
   end

   // Properties judge the held word; a flush cycle decodes as no-op
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   and_zero_a: assert property (is_and |=> zero_flag_out == ($past(and_res) == 8'h00))
      else $error("and result zero flag wrong");

   and_dest_a: assert property ((is_and && !dest_file) |=>
      work_out == $past(and_res))
      else $error("and destination wrong");

   and_wb_a: assert property ((is_and && dest_file) |=> work_out == $past(work_out))
      else $error("file destination touched working register");

   skip_zero_a: assert property ((is_btz && !tested_bit) |=>
      (flushing_out && $stable(zero_flag_out)) ##1 (state == st_run))
      else $error("skip on zero bit not taken");

   skip_one_a: assert property ((is_bto && tested_bit) |=> flushing_out ##1 !flushing_out)
      else $error("skip on one bit not taken");

   flush_nop_a: assert property ((state == st_flush) |=>
      $stable(work_out) && $stable(zero_flag_out) && !stack_push_out)
      else $error("flushed word was executed");

   no_skip_a: assert property (((is_btz && tested_bit) || (is_bto && !tested_bit)) |=>
      state == st_run && pc_out == $past(pc_out) + 11'h001)
      else $error("untaken bit test stalled");

   clear_working_register_a: assert property (is_clear_working_register |=> work_out == 8'h00 && zero_flag_out)
      else $error("clear working register failed");

   clear_file_register_a: assert property (is_clear_file_register |-> wr_en && wr_data == 8'h00 ##1 zero_flag_out)
      else $error("clear file register failed");

   call_push_a: assert property (is_call |=> stack_push_out
      && stack_data_out == $past(pc_out) ##1 !stack_push_out)
      else $error("call push wrong");

   call_pc_a: assert property (is_call |=>
      pc_out == {$past(page_select_in), 1'b0, $past(ir[7:0])})
      else $error("call target wrong");

   call_cycles_a: assert property (is_call |=>
      flushing_out && $stable(zero_flag_out) ##1 state == st_run)
      else $error("call not two cycles");

   wdt_clear_a: assert property (is_clear_watchdog_counter |=> watchdog_count_out == 8'h00
      && (!$past(prescaler_to_watchdog_in) || prescaler_count_out == 8'h00))
      else $error("watchdog clear failed");

   wdt_flags_a: assert property (is_clear_watchdog_counter |=> timeout_flag_n_out && powerdown_flag_n_out)
      else $error("status flags not set");

   and_file_a: assert property ((is_and && dest_file) |->
      wr_en && wr_data == and_res)
      else $error("and result not written to file");

   and_keep_a: assert property ((is_and && !dest_file) |->
      !wr_en)
      else $error("working destination wrote a file");

   btz_flags_a: assert property (is_btz |=>
      $stable(zero_flag_out) && $stable(timeout_flag_n_out) && $stable(powerdown_flag_n_out))
      else $error("skip on zero touched flags");

   bto_flags_a: assert property (is_bto |=>
      $stable(zero_flag_out) && $stable(timeout_flag_n_out) && $stable(powerdown_flag_n_out))
      else $error("skip on one touched flags");

   skip_pc_a: assert property (((is_btz && !tested_bit) || (is_bto && tested_bit)) |=>
      pc_out == $past(pc_out) + 11'h001 ##1 pc_out == $past(pc_out) + 11'h001)
      else $error("skip disturbed the fetch address");

   flush_pc_a: assert property ((state == st_flush) |=>
      pc_out == $past(pc_out) + 11'h001)
      else $error("flush cycle stalled the fetch");

   push_src_a: assert property (stack_push_out |->
      $past(is_call))
      else $error("push without a call");

   call_dest_a: assert property (is_call |->
      !wr_en && !wdt_clear)
      else $error("call wrote a file or cleared watchdog");

   call_flags_a: assert property (is_call |=>
      $stable(zero_flag_out) && $stable(work_out) && $stable(timeout_flag_n_out))
      else $error("call changed state it must keep");

   clear_working_register_file_a: assert property (is_clear_working_register |->
      !wr_en)
      else $error("clear working register wrote a file");

   zero_only_a: assert property ((exec && !is_and && !is_clear_file_register && !is_clear_working_register) |=>
      $stable(zero_flag_out))
      else $error("zero flag moved without a logic op");

   wdt_keep_a: assert property ((is_clear_watchdog_counter && !prescaler_to_watchdog_in) |=>
      prescaler_count_out == $past(prescaler_count_out))
      else $error("timer prescaler cleared by watchdog clear");

   clear_watchdog_counter_keep_a: assert property (is_clear_watchdog_counter |=>
      $stable(zero_flag_out) && $stable(work_out))
      else $error("watchdog clear touched zero or working");

   flag_hold_a: assert property (!is_clear_watchdog_counter |=>
      $stable(timeout_flag_n_out) && $stable(powerdown_flag_n_out))
      else $error("status flags moved without a clear");

   skip_taken_c: cover property (is_btz && !tested_bit ##2 is_bto && tested_bit);
   call_seen_c:  cover property (is_call ##2 is_and && dest_file);
   clear_watchdog_counter_c:     cover property (is_clear_watchdog_counter && prescaler_to_watchdog_in);
   clear_file_register_c:       cover property (is_clear_file_register ##1 is_clear_working_register);
   bit_pass_c:   cover property (is_bto && !tested_bit);

endmodule

// file: sim/program_memory_model.sv
`timescale 1ns/1ps
module program_memory_model (
   input  wire logic [exec_subset_pkg::PC_W-1:0]    addr_in,
   output logic      [exec_subset_pkg::INSTR_W-1:0] word_out
);
   import exec_subset_pkg::*;

   logic [INSTR_W-1:0] words [0:(1 << PC_W)-1];

   // Asynchronous read: the core fetches in the same cycle
   assign word_out = words[addr_in];

   // Unused space reads as no-op so runaway fetches stay harmless
   task automatic clear_all;
      for (int i = 0; i < (1 << PC_W); i++) begin
         words[i] = OP_NOP;
      end
   endtask
endmodule

// file: sim/mcu_instruction_exec_subset_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      fails++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (a), (b)); \
   end \
end
module mcu_instruction_exec_subset_tb;
   import exec_subset_pkg::*;

   logic                 mclk_in;
   logic                 reset_in;
   logic [INSTR_W-1:0]   instr_in;
   logic [PAGE_W-1:0]    page_select_in;
   logic                 prescaler_to_watchdog_in;
   logic [PC_W-1:0]      pc_out;
   logic                 stack_push_out;
   logic [PC_W-1:0]      stack_data_out;
   logic [WORD_W-1:0]    work_out;
   logic                 zero_flag_out;
   logic                 timeout_flag_n_out;
   logic                 powerdown_flag_n_out;
   logic                 flushing_out;
   logic [WORD_W-1:0]    watchdog_count_out;
   logic [WORD_W-1:0]    prescaler_count_out;
   int                   fails;
   int                   checks_done;

   exec_subset_core u_dut (
      .mclk_in                  (mclk_in),
      .reset_in                 (reset_in),
      .instr_in                 (instr_in),
      .page_select_in           (page_select_in),
      .prescaler_to_watchdog_in (prescaler_to_watchdog_in),
      .pc_out                   (pc_out),
      .stack_push_out           (stack_push_out),
      .stack_data_out           (stack_data_out),
      .work_out                 (work_out),
      .zero_flag_out            (zero_flag_out),
      .timeout_flag_n_out       (timeout_flag_n_out),
      .powerdown_flag_n_out     (powerdown_flag_n_out),
      .flushing_out             (flushing_out),
      .watchdog_count_out       (watchdog_count_out),
      .prescaler_count_out      (prescaler_count_out)
   );

   program_memory_model u_mem (
      .addr_in  (pc_out),
      .word_out (instr_in)
   );

   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic put(input logic [PC_W-1:0] a, input logic [INSTR_W-1:0] w);
      u_mem.words[a] = w;
   endtask

   // Four-cycle reset; the first edge after return fetches address 0
   task automatic do_reset(input logic [1:0] page, input logic psa);
      @(posedge mclk_in);
      reset_in                 <= 1'b1;
      page_select_in           <= page;
      prescaler_to_watchdog_in <= psa;
      repeat (4) @(posedge mclk_in);
      reset_in <= 1'b0;
   endtask

   // Sample at the falling edge, well clear of the launching edge
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask

   task automatic t_clear_file;
      u_mem.clear_all();
      put(11'h000, OP_CLEAR_FILE_REGISTER | 12'h003);
      do_reset(2'b00, 1'b0);
      step(1);
      `CHK(zero_flag_out, 1'b0)
      step(1);
      `CHK(zero_flag_out, 1'b1)
   endtask

   task automatic t_clear_work;
      u_mem.clear_all();
      put(11'h000, OP_CLEAR_WORKING_REGISTER);
      do_reset(2'b00, 1'b0);
      step(2);
      `CHK(work_out, 8'h00)
      `CHK(zero_flag_out, 1'b1)
   endtask

   // File 3 was zeroed by the clear-file scenario and is not reset
   task automatic t_and;
      u_mem.clear_all();
      put(11'h000, OP_AND_WORK_WITH_FILE | 12'h023);
      put(11'h001, OP_AND_WORK_WITH_FILE | 12'h003);
      put(11'h002, OP_BIT_TEST_SKIP_WHEN_ONE | 12'h003);
      do_reset(2'b00, 1'b0);
      step(2);
      `CHK(zero_flag_out, 1'b1)
      `CHK(work_out, 8'h00)
      step(2);
      `CHK(work_out, 8'h00)
      `CHK(flushing_out, 1'b0)
   endtask

   // A skipped call would redirect the fetch address
   task automatic t_skip;
      u_mem.clear_all();
      put(11'h000, OP_CLEAR_FILE_REGISTER | 12'h005);
      put(11'h001, OP_BIT_TEST_SKIP_WHEN_ZERO | 12'h0e5);
      put(11'h002, OP_CALL | 12'h080);
      put(11'h003, OP_BIT_TEST_SKIP_WHEN_ONE | 12'h005);
      put(11'h004, OP_CALL | 12'h040);
      do_reset(2'b00, 1'b0);
      step(3);
      `CHK(flushing_out, 1'b1)
      `CHK(pc_out, 11'h003)
      step(1);
      `CHK(pc_out, 11'h004)
      `CHK(stack_push_out, 1'b0)
      step(1);
      `CHK(flushing_out, 1'b0)
      `CHK(pc_out, 11'h005)
      `CHK(zero_flag_out, 1'b1)
      step(1);
      `CHK(pc_out, 11'h040)
      `CHK(stack_data_out, 11'h005)
   endtask

   task automatic t_call;
      u_mem.clear_all();
      put(11'h000, OP_CLEAR_FILE_REGISTER | 12'h003);
      put(11'h001, OP_CALL | 12'h0ff);
      do_reset(2'b10, 1'b0);
      step(3);
      `CHK(pc_out, 11'h4ff)
      `CHK(stack_push_out, 1'b1)
      `CHK(stack_data_out, 11'h002)
      `CHK(flushing_out, 1'b1)
      step(1);
      `CHK(pc_out, 11'h500)
      `CHK(stack_push_out, 1'b0)
      `CHK(flushing_out, 1'b0)
      `CHK(zero_flag_out, 1'b1)
   endtask

   task automatic t_watchdog(input logic psa);
      logic [7:0] pre_before;
      u_mem.clear_all();
      put(11'h03c, OP_CLEAR_WATCHDOG_COUNTER);
      do_reset(2'b00, psa);
      // Word at 3c is held from edge 61 and commits at edge 62
      step(61);
      pre_before = prescaler_count_out;
      `CHK(psa ? prescaler_count_out != 8'h00 : watchdog_count_out != 8'h00, 1'b1)
      step(1);
      `CHK(watchdog_count_out, 8'h00)
      `CHK(prescaler_count_out, psa ? 8'h00 : pre_before)
      `CHK(timeout_flag_n_out, 1'b1)
      `CHK(powerdown_flag_n_out, 1'b1)
   endtask

   initial begin
      #20000;
      fails++;
      end_of_test();
   end

   initial begin
      fails                    = 0;
      checks_done              = 0;
      reset_in                 = 1'b1;
      page_select_in           = 2'b00;
      prescaler_to_watchdog_in = 1'b0;
      u_mem.clear_all();
      t_clear_file();
      t_clear_work();
      t_and();
      t_skip();
      t_call();
      t_watchdog(1'b0);
      t_watchdog(1'b1);
      end_of_test();
   end
endmodule
